// *** design/abu_break_unit.sv ***
// How it works
// - break loads interrupt opcode, vector per mode
// - break starts at instruction end, immediate if last
// - dma holds off while break serviced
// - dma address match breaks at instruction end
// - dma releases buses at next address boundary or at break start
// - dma keeps arbitrating during break
// - dma resumes after break ends
// - timer counter frozen during break
// - watchdog suppressed in break with high voltage
// - enable bit 7 gates address match breaks
// - active bit set on match, reset clears
// - writing one to active bit raises break
// - address registers hold match, reset zero
// - comparison and dma work in wait mode
// - stop/wait flag set on dma match in wait
// - dma write to control in wait sets stop/wait flag
// - writing zero clears stop/wait flag
// - break in stop mode exits stop, sets flag
// - address match asserts breakpoint request
// - return from interrupt ends the break
module abu_break_unit
    import abu_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // register port
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_from_dma,
    output logic [7:0] reg_rdata,
    // internal address bus
    input wire logic [15:0] bus_addr,
    input wire logic bus_addr_valid,
    input wire logic bus_from_dma,
    // cpu sequencing
    input wire logic cpu_last_cycle,
    input wire logic cpu_return_exec,
    input wire logic monitor_mode,
    output logic breakpoint_request,
    output logic cpu_break_start,
    output logic [7:0] cpu_load_opcode,
    output logic [15:0] cpu_vector_addr,
    // power modes
    input wire logic wait_mode,
    input wire logic stop_mode,
    output logic stop_exit,
    // dma control
    input wire logic dma_addr_boundary,
    output logic dma_hold,
    output logic dma_arbitrate_en,
    // timer and watchdog
    input wire logic rst_pin_high_volt,
    output logic timer_freeze,
    output logic watchdog_suppress
);
    import abu_pkg::*;

    logic [7:0] addr_high_q;
    logic [7:0] addr_low_q;
    logic enable_q;
    logic active_q;
    logic stop_wait_q;
    logic [2:0] hv_sync_q;
    logic hv_q;
    abu_state_t state_q;
    abu_state_t state_d;
    logic hold_q;

    logic wr_high;
    logic wr_low;
    logic wr_ctrl;
    logic wr_stop_wait;
    logic addr_match;
    logic sw_break;
    logic break_event;

    assign wr_high = reg_wr && (reg_addr == ABU_ADDR_HIGH_OFS);
    assign wr_low = reg_wr && (reg_addr == ABU_ADDR_LOW_OFS);
    assign wr_ctrl = reg_wr && (reg_addr == ABU_CTRL_OFS);
    assign wr_stop_wait = reg_wr && (reg_addr == ABU_STOP_WAIT_OFS);

    // comparator stays live in wait mode so dma traffic can break
    assign addr_match = enable_q && bus_addr_valid
        && (bus_addr == {addr_high_q, addr_low_q});
    assign sw_break = wr_ctrl && reg_wdata[ABU_ACTIVE_BIT];
    assign break_event = addr_match || sw_break;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            addr_high_q <= ABU_ADDR_RESET;
            addr_low_q <= ABU_ADDR_RESET;
        end else begin
            if (wr_high) begin
                addr_high_q <= reg_wdata;
            end
            if (wr_low) begin
                addr_low_q <= reg_wdata;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            enable_q <= 1'b0;
        end else if (wr_ctrl) begin
            enable_q <= reg_wdata[ABU_ENABLE_BIT];
        end
    end

    // a match in the clearing cycle wins over the software clear
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            active_q <= 1'b0;
        end else if (break_event) begin
            active_q <= 1'b1;
        end else if (wr_ctrl) begin
            active_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            stop_wait_q <= 1'b0;
        end else if ((addr_match && bus_from_dma && wait_mode)
                     || (wr_ctrl && reg_from_dma && wait_mode)
                     || (break_event && stop_mode)) begin
            stop_wait_q <= 1'b1;
        end else if (wr_stop_wait && !reg_wdata[ABU_STOP_WAIT_BIT]) begin
            stop_wait_q <= 1'b0;
        end
    end

    // routine reads the stop/wait flag to decide on returning to wait
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                ABU_ADDR_HIGH_OFS: reg_rdata <= addr_high_q;
                ABU_ADDR_LOW_OFS: reg_rdata <= addr_low_q;
                ABU_CTRL_OFS: reg_rdata <= {enable_q, active_q, 6'h00};
                ABU_STOP_WAIT_OFS: reg_rdata <= {6'h00, stop_wait_q, 1'b0};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // high-voltage detect is a pin: three flops, act when last two agree
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            hv_sync_q <= 3'h0;
            hv_q <= 1'b0;
        end else begin
            hv_sync_q <= {hv_sync_q[1:0], rst_pin_high_volt};
            if (hv_sync_q[1] == hv_sync_q[2]) begin
                hv_q <= hv_sync_q[2];
            end
        end
    end

    // break sequencer
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ABU_IDLE: begin
                if (break_event) begin
                    state_d = cpu_last_cycle ? ABU_BREAK : ABU_PEND;
                end
            end
            ABU_PEND: begin
                if (cpu_last_cycle) begin
                    state_d = ABU_BREAK;
                end
            end
            ABU_BREAK: begin
                if (cpu_return_exec) begin
                    state_d = ABU_IDLE;
                end
            end
            default: state_d = ABU_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_q <= ABU_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // while a break is pending dma keeps its bus until an address boundary; break entry holds it at once
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            hold_q <= 1'b0;
        end else if (state_d == ABU_IDLE) begin
            hold_q <= 1'b0;
        end else if (dma_addr_boundary || state_d == ABU_BREAK) begin
            hold_q <= 1'b1;
        end
    end

    assign breakpoint_request = (state_q != ABU_IDLE);
    assign cpu_break_start = (state_q != ABU_BREAK) && (state_d == ABU_BREAK);
    assign cpu_load_opcode = ABU_SW_INT_OPCODE;
    assign cpu_vector_addr = monitor_mode ? ABU_VEC_MONITOR : ABU_VEC_USER;
    assign dma_hold = hold_q || (state_q == ABU_BREAK);
    assign dma_arbitrate_en = 1'b1;
    assign timer_freeze = (state_q == ABU_BREAK);
    assign watchdog_suppress = (state_q == ABU_BREAK) && hv_q;
    assign stop_exit = stop_mode && break_event;

    // break entry and exit
    chk_break_end: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_q == ABU_BREAK && cpu_return_exec |=> state_q == ABU_IDLE)
        else $error("break did not end on return");

    chk_immediate_start: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_q == ABU_IDLE && break_event && cpu_last_cycle |=> timer_freeze)
        else $error("break not immediate on last cycle");

    chk_pend_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_q == ABU_PEND && !cpu_last_cycle |=> !timer_freeze)
        else $error("break began before instruction end");

    chk_pend_start: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_q == ABU_PEND && cpu_last_cycle |-> cpu_break_start)
        else $error("pending break missed instruction end");

    chk_start_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
        cpu_break_start |=> !cpu_break_start && timer_freeze)
        else $error("break start not a single pulse");

    // vector and opcode handed to the cpu
    chk_vector_user: assert property (@(posedge core_clk) disable iff (!rst_n)
        cpu_break_start && !monitor_mode |-> cpu_vector_addr == ABU_VEC_USER)
        else $error("wrong user break vector");

    chk_vector_monitor: assert property (@(posedge core_clk) disable iff (!rst_n)
        cpu_break_start && monitor_mode |-> cpu_vector_addr == ABU_VEC_MONITOR)
        else $error("wrong monitor break vector");

    chk_opcode_load: assert property (@(posedge core_clk) disable iff (!rst_n)
        cpu_break_start |-> cpu_load_opcode == ABU_SW_INT_OPCODE)
        else $error("wrong opcode on break entry");

    // dma behaviour around a break
    chk_dma_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
        timer_freeze |-> dma_hold)
        else $error("dma not held during break");

    chk_break_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_q == ABU_BREAK |-> dma_hold)
        else $error("dma free in break state");

    chk_dma_match_pend: assert property (@(posedge core_clk) disable iff (!rst_n)
        addr_match && bus_from_dma && state_q == ABU_IDLE && !cpu_last_cycle
        |=> breakpoint_request && !timer_freeze)
        else $error("dma match did not wait for instruction end");

    chk_boundary_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_q == ABU_PEND && dma_addr_boundary |=> dma_hold)
        else $error("dma kept bus past boundary");

    chk_arbitrate_on: assert property (@(posedge core_clk) disable iff (!rst_n)
        timer_freeze |-> dma_arbitrate_en)
        else $error("dma arbitration stopped in break");

    chk_dma_resume: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_q == ABU_BREAK && cpu_return_exec |=> !dma_hold)
        else $error("dma not resumed after break");

    chk_idle_released: assert property (@(posedge core_clk) disable iff (!rst_n)
        !breakpoint_request |-> !dma_hold && !timer_freeze && !watchdog_suppress)
        else $error("break outputs high while idle");

    // timer and watchdog
    chk_timer_freeze: assert property (@(posedge core_clk) disable iff (!rst_n)
        timer_freeze |-> breakpoint_request && dma_hold)
        else $error("timer frozen outside break");

    chk_wdog: assert property (@(posedge core_clk) disable iff (!rst_n)
        watchdog_suppress |-> timer_freeze && hv_q)
        else $error("watchdog suppressed outside break");

    chk_wdog_on: assert property (@(posedge core_clk) disable iff (!rst_n)
        timer_freeze && hv_q |-> watchdog_suppress)
        else $error("watchdog not suppressed in break");

    chk_hv_ignored: assert property (@(posedge core_clk) disable iff (!rst_n)
        !hv_q |-> !watchdog_suppress)
        else $error("watchdog suppressed without high voltage");

    // control and address registers
    chk_active_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        addr_match |=> active_q)
        else $error("active flag missed match");

    chk_active_read: assert property (@(posedge core_clk) disable iff (!rst_n)
        reg_rd && reg_addr == ABU_CTRL_OFS |=> reg_rdata[ABU_ACTIVE_BIT] == $past(active_q))
        else $error("active flag read back wrong");

    chk_sw_break: assert property (@(posedge core_clk) disable iff (!rst_n)
        sw_break && state_q == ABU_IDLE |=> breakpoint_request)
        else $error("software break not raised");

    chk_sw_active: assert property (@(posedge core_clk) disable iff (!rst_n)
        sw_break |=> active_q)
        else $error("software break did not set active flag");

    chk_active_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_ctrl && !reg_wdata[ABU_ACTIVE_BIT] && !addr_match |=> !active_q)
        else $error("active flag not cleared");

    chk_disabled_match: assert property (@(posedge core_clk) disable iff (!rst_n)
        !enable_q |-> !addr_match)
        else $error("match while disabled");

    chk_enable_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_ctrl && reg_wdata[ABU_ENABLE_BIT] |=> enable_q)
        else $error("enable bit not set");

    chk_enable_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_ctrl && !reg_wdata[ABU_ENABLE_BIT] |=> !enable_q)
        else $error("enable bit not cleared");

    chk_addr_high_load: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_high |=> addr_high_q == $past(reg_wdata))
        else $error("high address byte not loaded");

    chk_addr_low_load: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_low |=> addr_low_q == $past(reg_wdata))
        else $error("low address byte not loaded");

    // wait and stop modes, and the breakpoint request on a match
    chk_wait_compare: assert property (@(posedge core_clk) disable iff (!rst_n)
        addr_match && wait_mode && !cpu_return_exec |=> breakpoint_request)
        else $error("no break on match in wait");

    chk_dma_wait_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
        addr_match && bus_from_dma && wait_mode |=> stop_wait_q)
        else $error("stop wait flag missed dma match");

    chk_stop_wait_dma: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_ctrl && reg_from_dma && wait_mode |=> stop_wait_q)
        else $error("stop wait flag not set");

    chk_stop_wait_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_stop_wait && !reg_wdata[ABU_STOP_WAIT_BIT] && !break_event && !wait_mode
        |=> !stop_wait_q)
        else $error("stop wait flag not cleared");

    chk_stop_exit: assert property (@(posedge core_clk) disable iff (!rst_n)
        stop_mode && break_event |-> stop_exit ##1 stop_wait_q)
        else $error("stop exit missing");

    chk_stop_exit_only: assert property (@(posedge core_clk) disable iff (!rst_n)
        stop_exit |-> stop_mode && break_event)
        else $error("stop exit without break in stop");

    chk_request_match: assert property (@(posedge core_clk) disable iff (!rst_n)
        addr_match && !cpu_return_exec |=> breakpoint_request)
        else $error("match raised no breakpoint request");

    // main scenarios
    cov_cpu_match: cover property (@(posedge core_clk) disable iff (!rst_n)
        addr_match && !bus_from_dma ##[1:20] cpu_return_exec);
    cov_pend_break: cover property (@(posedge core_clk) disable iff (!rst_n)
        state_q == ABU_PEND ##1 cpu_break_start);
    cov_dma_wait: cover property (@(posedge core_clk) disable iff (!rst_n)
        addr_match && bus_from_dma && wait_mode);
    cov_sw_break: cover property (@(posedge core_clk) disable iff (!rst_n)
        sw_break ##[1:10] cpu_break_start);
    cov_stop: cover property (@(posedge core_clk) disable iff (!rst_n) stop_exit);
endmodule : abu_break_unit

// *** design/abu_pkg.sv ***
package abu_pkg;
    // register map; printed offsets are byte addresses of a 16-bit map
    localparam logic [15:0] ABU_ADDR_HIGH_OFS = 16'hfe0c;
    localparam logic [15:0] ABU_ADDR_LOW_OFS = 16'hfe0d;
    localparam logic [15:0] ABU_CTRL_OFS = 16'hfe0e;
    localparam logic [15:0] ABU_STOP_WAIT_OFS = 16'hfe10;
    // field positions
    localparam int ABU_ENABLE_BIT = 7;
    localparam int ABU_ACTIVE_BIT = 6;
    localparam int ABU_STOP_WAIT_BIT = 1;
    // reset values
    localparam logic [7:0] ABU_ADDR_RESET = 8'h00;
    // vectors and opcodes
    localparam logic [15:0] ABU_VEC_USER = 16'hfffc;
    localparam logic [15:0] ABU_VEC_MONITOR = 16'hfefc;
    localparam logic [7:0] ABU_SW_INT_OPCODE = 8'h83;
    typedef enum logic [1:0] {
        ABU_IDLE = 2'b00,
        ABU_PEND = 2'b01,
        ABU_BREAK = 2'b10
    } abu_state_t;
endpackage : abu_pkg

// *** sim/abu_cpu_model.sv ***
module abu_cpu_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // bench control
    input wire logic long_instr,
    // toward the unit
    output logic cpu_last_cycle
);
    timeunit 1ns;
    timeprecision 1ps;
    // a long instruction keeps its final cycle away, so a match must wait as pending
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cpu_last_cycle <= 1'h0;
        end else begin
            cpu_last_cycle <= !long_instr;
        end
    end
endmodule : abu_cpu_model

// *** sim/testbench.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import abu_pkg::*;
    logic core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, reg_from_dma = 0;
    logic [15:0] reg_addr = 0, bus_addr = 0;
    logic [7:0] reg_wdata = 0, reg_rdata, cpu_load_opcode;
    logic bus_addr_valid = 0, bus_from_dma = 0, cpu_return_exec = 0, monitor_mode = 0;
    logic wait_mode = 0, stop_mode = 0, dma_addr_boundary = 0, rst_pin_high_volt = 0;
    logic long_instr = 0, cpu_last_cycle, breakpoint_request, cpu_break_start, stop_exit;
    logic dma_hold, dma_arbitrate_en, timer_freeze, watchdog_suppress;
    logic [15:0] cpu_vector_addr;
    int n_mismatch = 0, n_compared = 0;
    always #2.5 core_clk = ~core_clk;
    abu_cpu_model abu_cpu_model_i (.core_clk, .rst_n, .long_instr, .cpu_last_cycle);
    abu_break_unit abu_break_unit_i (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_from_dma, .reg_rdata, .bus_addr, .bus_addr_valid, .bus_from_dma,
        .cpu_last_cycle, .cpu_return_exec, .monitor_mode, .breakpoint_request,
        .cpu_break_start, .cpu_load_opcode, .cpu_vector_addr, .wait_mode, .stop_mode,
        .stop_exit, .dma_addr_boundary, .dma_hold, .dma_arbitrate_en, .rst_pin_high_volt,
        .timer_freeze, .watchdog_suppress);
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [15:0] a, input logic [7:0] d, input logic dma);
        @(posedge core_clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        reg_from_dma <= dma;
        @(posedge core_clk);
        reg_wr <= 1'h0;
        reg_from_dma <= 1'h0;
    endtask : wr
    task rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1 chk(16'(reg_rdata), 16'(exp));
    endtask : rd
    // one address cycle on the internal bus
    task match(input logic dma);
        @(posedge core_clk);
        bus_addr <= 16'h1234;
        bus_addr_valid <= 1'h1;
        bus_from_dma <= dma;
        @(posedge core_clk);
        bus_addr_valid <= 1'h0;
        bus_from_dma <= 1'h0;
    endtask : match
    // the routine clears the active bit first, then returns
    task leave;
        wr(ABU_CTRL_OFS, 8'h80, 1'h0);
        @(posedge core_clk);
        cpu_return_exec <= 1'h1;
        @(posedge core_clk);
        cpu_return_exec <= 1'h0;
        #1 chk(16'({breakpoint_request, timer_freeze, dma_hold}), 16'h0);
    endtask : leave
    task end_sim;
        $display("mismatches %0d compared %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        #20000;
        n_mismatch++;
        end_sim();
    end
    initial begin
        repeat (6) @(posedge core_clk);
        rst_n <= 1'h1;
        rd(ABU_ADDR_HIGH_OFS, 8'h00);
        rd(ABU_ADDR_LOW_OFS, 8'h00);
        rd(ABU_CTRL_OFS, 8'h00);
        rd(16'hfe20, 8'h00);
        wr(ABU_ADDR_HIGH_OFS, 8'h12, 1'h0);
        wr(ABU_ADDR_LOW_OFS, 8'h34, 1'h0);
        rd(ABU_ADDR_HIGH_OFS, 8'h12);
        rd(ABU_ADDR_LOW_OFS, 8'h34);
        match(1'h0);
        #1 chk(16'(breakpoint_request), 16'h0);
        wr(ABU_CTRL_OFS, 8'h80, 1'h0);
        rd(ABU_CTRL_OFS, 8'h80);
        long_instr <= 1'h1;
        match(1'h0);
        #1 chk(16'({breakpoint_request, timer_freeze}), 16'h2);
        @(posedge core_clk);
        dma_addr_boundary <= 1'h1;
        @(posedge core_clk);
        dma_addr_boundary <= 1'h0;
        #1 chk(16'(dma_hold), 16'h1);
        long_instr <= 1'h0;
        repeat (3) @(posedge core_clk);
        #1 chk(16'({timer_freeze, dma_hold, dma_arbitrate_en}), 16'h7);
        chk(cpu_vector_addr, ABU_VEC_USER);
        chk(16'(cpu_load_opcode), 16'(ABU_SW_INT_OPCODE));
        rd(ABU_CTRL_OFS, 8'hc0);
        leave();
        monitor_mode <= 1'h1;
        rst_pin_high_volt <= 1'h1;
        wr(ABU_CTRL_OFS, 8'hc0, 1'h0);
        repeat (4) @(posedge core_clk);
        #1 chk(16'({timer_freeze, watchdog_suppress}), 16'h3);
        chk(cpu_vector_addr, ABU_VEC_MONITOR);
        leave();
        monitor_mode <= 1'h0;
        rst_pin_high_volt <= 1'h0;
        wait_mode <= 1'h1;
        match(1'h1);
        #1 chk(16'(timer_freeze), 16'h1);
        rd(ABU_STOP_WAIT_OFS, 8'h02);
        leave();
        wr(ABU_STOP_WAIT_OFS, 8'h00, 1'h0);
        rd(ABU_STOP_WAIT_OFS, 8'h00);
        wr(ABU_CTRL_OFS, 8'h80, 1'h1);
        rd(ABU_STOP_WAIT_OFS, 8'h02);
        wr(ABU_STOP_WAIT_OFS, 8'h00, 1'h0);
        wait_mode <= 1'h0;
        stop_mode <= 1'h1;
        @(posedge core_clk);
        reg_wr <= 1'h1;
        reg_addr <= ABU_CTRL_OFS;
        reg_wdata <= 8'hc0;
        #1 chk(16'({stop_exit, cpu_break_start}), 16'h3);
        @(posedge core_clk);
        reg_wr <= 1'h0;
        stop_mode <= 1'h0;
        rd(ABU_STOP_WAIT_OFS, 8'h02);
        leave();
        end_sim();
    end
endmodule : testbench
